// ==== hdl/scpt_clk_div.sv ====
`timescale 1ns/10ps
`include "scpt_consts.svh"

module scpt_clk_div
   import scpt_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire logic         tick,
   input  wire logic [W-1:0] div,
   output logic              clk_out
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         wrap;
   logic         out_d;

   // Period is div ticks, high for the first half; div of 0 or 1 passes tick through
   assign wrap  = (cnt_q + W'(1)) >= div;
   assign cnt_d = wrap ? '0 : cnt_q + W'(1);
   assign out_d = (div <= W'(1)) ? tick : (cnt_q < (div >> 1));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q   <= '0;
         clk_out <= 1'b0;
      end else if (ce) begin
         if (tick) begin
            cnt_q <= cnt_d;
         end
         clk_out <= out_d;
      end
   end

endmodule : scpt_clk_div

// ==== hdl/scpt_consts.svh ====
`ifndef SCPT_CONSTS_SVH
`define SCPT_CONSTS_SVH

// Register addresses
`define SCPT_A_NOISE     15'h002B
`define SCPT_A_DIVPV     15'h003D
`define SCPT_A_DIVN      15'h003E
`define SCPT_A_HOLD      15'h005C
`define SCPT_A_CALEN     15'h005D
`define SCPT_A_CALDONE   15'h005E
`define SCPT_A_LOCK      15'h0208
`define SCPT_A_TRIG      15'h0030
`define SCPT_A_REFO      15'h0031
`define SCPT_A_AUX       15'h0032
`define SCPT_A_MARK      15'h0033

// Field positions
`define SCPT_PV_P        7:4
`define SCPT_PV_V        3:0
`define SCPT_TRIG_EN     0
`define SCPT_TRIG_MODE   2:1
`define SCPT_TRIG_DIV    7:4
`define SCPT_AUX_C       1:0
`define SCPT_AUX_D       3:2
`define SCPT_AUX_OVR     4
`define SCPT_MARK_OUT    0
`define SCPT_MARK_RECV   1
`define SCPT_NOISE_F     1:0

// Field values
`define SCPT_TRIG_MARKER 2'h3
`define SCPT_AUX_OFF     2'h0
`define SCPT_AUX_REF     2'h1
`define SCPT_AUX_DIV2    2'h2
`define SCPT_DIV2        8'h02
`define SCPT_DIV4        8'h04

// Reset values
`define SCPT_RST_ZERO    8'h00
`define SCPT_RST_HOLD    8'h01
`define SCPT_RST_REFO    8'h01

// Serial access frame
`define SCPT_SPI_HDR_LAST 5'h0F
`define SCPT_SPI_LAST     5'h17
`define SCPT_SPI_DATA     5'h10

// Timing
`define SCPT_CLK_PS      5000
`define SCPT_CAL_NS      2000
`define SCPT_LOCK_NS     1000
`define SCPT_MARK_LAT    4

`endif

// ==== hdl/scpt_marker_path.sv ====
`timescale 1ns/10ps
`include "scpt_consts.svh"

module scpt_marker_path
   import scpt_pkg::*;
#(
   parameter int LAT = `SCPT_MARK_LAT
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        marker_input,
   input  wire logic        ts_out_en,
   input  wire logic        recv_en,
   input  wire logic [11:0] sample_in,
   input  wire logic        sample_valid,
   output logic             marker_retimed,
   output logic [11:0]      link_word,
   output logic             link_valid
);

   logic           sync_m_q;
   logic [LAT-1:0] dly_q;
   logic           mark_now;
   logic [11:0]    word_d;

   // Receiver gates the marker before it is sampled
   assign mark_now = marker_retimed & recv_en;
   assign word_d   = ts_out_en ? {sample_in[11:1], dly_q[LAT-1]}
                               : sample_in;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync_m_q       <= 1'b0;
         marker_retimed <= 1'b0;
         dly_q          <= '0;
         link_word      <= '0;
         link_valid     <= 1'b0;
      end else if (ce) begin
         sync_m_q       <= marker_input;
         marker_retimed <= sync_m_q;
         dly_q          <= {dly_q[LAT-2:0], mark_now};
         link_word      <= word_d;
         link_valid     <= sample_valid;
      end
   end

   link_lsb_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && ts_out_en |=> link_word[0] == $past(dly_q[LAT-1])
                          && link_word[11:1] == $past(sample_in[11:1]))
      else $error("marker bit not in link word lsb");

   marker_lat_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && !recv_en) [*4] |=> dly_q[LAT-1] == 1'b0)
      else $error("marker seen with receiver off");

endmodule : scpt_marker_path

// ==== hdl/scpt_pkg.sv ====
package scpt_pkg;

   typedef logic [7:0] scpt_byte_t;

   typedef enum logic [2:0] {
      SCPT_ST_HOLD,
      SCPT_ST_CAL,
      SCPT_ST_LOCKWAIT,
      SCPT_ST_LOCKED,
      SCPT_ST_FAIL
   } scpt_lock_state_t;

endpackage : scpt_pkg

// ==== hdl/scpt_top.sv ====
`timescale 1ns/10ps
`include "scpt_consts.svh"

// Operation
// - Marker input retimed, repeated on trigger output when enabled and select is 3.
// - With marker output and receiver on, link word bit 0 is marker, sample in [11:1].
// - Marker sampled like a 1-bit conversion, with sample latency, input may be async.
// - Synth enable pin enables synthesizer; select pin high picks single-ended reference.
// - Both pins low bypass synthesizer, differential input is sampling clock.
// - Power-down pin high forces every clock output off.
// - Sampling rate is VCO over V times P, and reference times N.
// - Prescaler and VCO divider at one address, feedback divider at next.
// - With calibration enabled, releasing synthesizer reset starts VCO calibration.
// - Calibration done and lock status registers read 1 when reached.
// - Clock control register holds two supply noise suppression bits.
// - Reference repeat output copies selected reference, enabled by default, bit can clear.
// - Reference repeat drives only with synth pin high and power-down low.
// - Trigger output off after reset; sourced from marker or serializer clock.
// - Serializer source gives line rate divided by programmable receiver divider.
// - One sampling clock feeds cores, digital logic and serializer synthesizer.
// - Aux outputs give direct or divided reference, from config pins or registers.
// - Pins set aux C divider; aux D divider only via its register field.
module scpt_top
   import scpt_pkg::*;
#(
   parameter int MARK_LAT = `SCPT_MARK_LAT
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        spi_sclk,
   input  wire logic        spi_csn,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_oe,
   input  wire logic        synth_enable_pin,
   input  wire logic        ref_select_pin,
   input  wire logic        power_down_pin,
   input  wire logic [1:0]  aux_clock_config_pins,
   input  wire logic        diff_ref_input,
   input  wire logic        single_ended_ref_input,
   input  wire logic        serial_line_tick,
   input  wire logic        marker_input,
   input  wire logic [11:0] sample_in,
   input  wire logic        sample_valid,
   output logic [11:0]      link_word,
   output logic             link_valid,
   output logic             sample_clk_select,
   output logic             synth_reset_out,
   output logic [1:0]       noise_suppress,
   output logic             reference_repeat_output,
   output logic             aux_clock_out_c,
   output logic             aux_clock_out_d,
   output logic             trigger_clock_output
);

   localparam int CAL_CYC  =
      (`SCPT_CAL_NS * 1000 + `SCPT_CLK_PS - 1) / `SCPT_CLK_PS;
   localparam int LOCK_CYC =
      (`SCPT_LOCK_NS * 1000 + `SCPT_CLK_PS - 1) / `SCPT_CLK_PS;

   // Allowed V x P products
   function automatic logic vp_ok(input logic [3:0] p, input logic [3:0] v);
      logic [7:0] prod;
      prod = 8'(p * v);
      vp_ok = (prod == 8'h05) || (prod == 8'h06) || (prod == 8'h08) ||
              (prod == 8'h0A) || (prod == 8'h0C) || (prod == 8'h10);
   endfunction : vp_ok

   // Aux output source by mode
   function automatic logic aux_pick(input logic [1:0] mode,
                                     input logic ref_l, input logic d2,
                                     input logic d4);
      case (mode)
         `SCPT_AUX_OFF:  aux_pick = 1'b0;
         `SCPT_AUX_REF:  aux_pick = ref_l;
         `SCPT_AUX_DIV2: aux_pick = d2;
         default:        aux_pick = d4;
      endcase
   endfunction : aux_pick

   // Pin synchronisers
   logic       sclk_m_q, sclk_s_q, sclk_l_q;
   logic       csn_m_q, csn_s_q;
   logic       sdi_m_q, sdi_s_q;
   logic       syn_m_q, syn_s_q, sel_m_q, sel_s_q, pd_m_q, pd_s_q;
   logic [1:0] cfg_m_q, cfg_s_q;
   logic       dref_m_q, dref_s_q, sref_m_q, sref_s_q, ref_l_q;

   // Registers
   scpt_byte_t noise_q, pv_q, n_q, hold_q, calen_q;
   scpt_byte_t trig_q, refo_q, aux_q, mark_q;
   logic       cal_done_q, lock_q;

   // Serial access
   logic [4:0]  cnt_q;
   logic [22:0] shin_q;
   logic [7:0]  sdo_sh_q;
   logic        rw_q;
   logic [14:0] addr_q;

   scpt_lock_state_t st_q;
   logic [15:0]      tmr_q;

   wire sclk_rise = sclk_s_q & ~sclk_l_q;
   wire sclk_fall = ~sclk_s_q & sclk_l_q;
   wire bit_in    = sclk_rise & ~csn_s_q;
   wire hdr_done  = bit_in && (cnt_q == `SCPT_SPI_HDR_LAST);
   wire [15:0] hdr_w = {shin_q[14:0], sdi_s_q};
   wire wr_stb    = bit_in && (cnt_q == `SCPT_SPI_LAST) && !rw_q;
   wire [7:0] wdata = {shin_q[6:0], sdi_s_q};
   wire data_ph   = ~csn_s_q && rw_q && (cnt_q >= `SCPT_SPI_DATA);

   // Read decode
   wire [14:0] ra = hdr_w[14:0];
   wire [7:0] rd_data =
      (ra == `SCPT_A_NOISE)   ? noise_q :
      (ra == `SCPT_A_DIVPV)   ? pv_q :
      (ra == `SCPT_A_DIVN)    ? n_q :
      (ra == `SCPT_A_HOLD)    ? hold_q :
      (ra == `SCPT_A_CALEN)   ? calen_q :
      (ra == `SCPT_A_CALDONE) ? {7'h00, cal_done_q} :
      (ra == `SCPT_A_LOCK)    ? {7'h00, lock_q} :
      (ra == `SCPT_A_TRIG)    ? trig_q :
      (ra == `SCPT_A_REFO)    ? refo_q :
      (ra == `SCPT_A_AUX)     ? aux_q :
      (ra == `SCPT_A_MARK)    ? mark_q : 8'h00;

   // Clock selection
   wire synth_on = syn_s_q;
   wire ref_sel  = (synth_on && sel_s_q) ? sref_s_q : dref_s_q;
   wire ref_rise = ref_sel & ~ref_l_q;
   wire sclk_sel_d = synth_on;

   // Aux modes: pins unless register override
   wire       ovr    = aux_q[`SCPT_AUX_OVR];
   wire [1:0] c_mode = ovr ? aux_q[`SCPT_AUX_C] : cfg_s_q;
   wire [1:0] d_pin  = (cfg_s_q != `SCPT_AUX_OFF) ? `SCPT_AUX_REF
                                                  : `SCPT_AUX_OFF;
   wire [1:0] d_raw  = ovr ? aux_q[`SCPT_AUX_D] : d_pin;
   wire [1:0] d_mode = (c_mode != `SCPT_AUX_OFF) ? d_raw : `SCPT_AUX_OFF;

   logic ref_d2, ref_d4, ser_div, mark_rt;

   wire refo_d = synth_on && !pd_s_q && refo_q[0] && ref_sel;
   wire auxc_d = !pd_s_q && aux_pick(c_mode, ref_sel, ref_d2, ref_d4);
   wire auxd_d = !pd_s_q && aux_pick(d_mode, ref_sel, ref_d2, ref_d4);
   wire trig_en   = trig_q[`SCPT_TRIG_EN];
   wire trig_mark = trig_q[`SCPT_TRIG_MODE] == `SCPT_TRIG_MARKER;
   wire trig_d = !pd_s_q && trig_en &&
                 (trig_mark ? mark_rt : ser_div);

   // Lock sequence
   wire hold_fall = wr_stb && (addr_q == `SCPT_A_HOLD) &&
                    hold_q[0] && !wdata[0];
   wire div_ok    = vp_ok(pv_q[`SCPT_PV_P], pv_q[`SCPT_PV_V]) &&
                    (n_q != `SCPT_RST_ZERO);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         {sclk_m_q, sclk_s_q, sclk_l_q} <= 3'h0;
         {csn_m_q, csn_s_q}             <= 2'h3;
         {sdi_m_q, sdi_s_q}             <= 2'h0;
         {syn_m_q, syn_s_q, sel_m_q, sel_s_q} <= 4'h0;
         {pd_m_q, pd_s_q}               <= 2'h0;
         {cfg_m_q, cfg_s_q}             <= 4'h0;
         {dref_m_q, dref_s_q, sref_m_q, sref_s_q, ref_l_q} <= 5'h00;
      end else if (ce) begin
         sclk_m_q <= spi_sclk;
         sclk_s_q <= sclk_m_q;
         sclk_l_q <= sclk_s_q;
         csn_m_q  <= spi_csn;
         csn_s_q  <= csn_m_q;
         sdi_m_q  <= spi_sdi;
         sdi_s_q  <= sdi_m_q;
         syn_m_q  <= synth_enable_pin;
         syn_s_q  <= syn_m_q;
         sel_m_q  <= ref_select_pin;
         sel_s_q  <= sel_m_q;
         pd_m_q   <= power_down_pin;
         pd_s_q   <= pd_m_q;
         cfg_m_q  <= aux_clock_config_pins;
         cfg_s_q  <= cfg_m_q;
         dref_m_q <= diff_ref_input;
         dref_s_q <= dref_m_q;
         sref_m_q <= single_ended_ref_input;
         sref_s_q <= sref_m_q;
         ref_l_q  <= ref_sel;
      end
   end

   // Serial shifter
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q      <= 5'h00;
         shin_q     <= '0;
         sdo_sh_q   <= 8'h00;
         rw_q       <= 1'b0;
         addr_q     <= 15'h0000;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else if (ce) begin
         if (csn_s_q) begin
            cnt_q <= 5'h00;
         end else if (bit_in) begin
            cnt_q  <= cnt_q + 5'h01;
            shin_q <= {shin_q[21:0], sdi_s_q};
         end
         if (hdr_done) begin
            rw_q     <= hdr_w[15];
            addr_q   <= hdr_w[14:0];
            sdo_sh_q <= rd_data;
         end else if (sclk_fall && data_ph) begin
            spi_sdo  <= sdo_sh_q[7];
            sdo_sh_q <= {sdo_sh_q[6:0], 1'b0};
         end
         spi_sdo_oe <= data_ph;
      end
   end

   // Register writes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         noise_q <= `SCPT_RST_ZERO;
         pv_q    <= `SCPT_RST_ZERO;
         n_q     <= `SCPT_RST_ZERO;
         hold_q  <= `SCPT_RST_HOLD;
         calen_q <= `SCPT_RST_ZERO;
         trig_q  <= `SCPT_RST_ZERO;
         refo_q  <= `SCPT_RST_REFO;
         aux_q   <= `SCPT_RST_ZERO;
         mark_q  <= `SCPT_RST_ZERO;
      end else if (ce && wr_stb) begin
         case (addr_q)
            `SCPT_A_NOISE: noise_q <= wdata;
            `SCPT_A_DIVPV: pv_q    <= wdata;
            `SCPT_A_DIVN:  n_q     <= wdata;
            `SCPT_A_HOLD:  hold_q  <= wdata;
            `SCPT_A_CALEN: calen_q <= wdata;
            `SCPT_A_TRIG:  trig_q  <= wdata;
            `SCPT_A_REFO:  refo_q  <= wdata;
            `SCPT_A_AUX:   aux_q   <= wdata;
            `SCPT_A_MARK:  mark_q  <= wdata;
            default: ;
         endcase
      end
   end

   // Calibration and lock model
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q       <= SCPT_ST_HOLD;
         tmr_q      <= 16'h0000;
         cal_done_q <= 1'b0;
         lock_q     <= 1'b0;
      end else if (ce) begin
         if (hold_q[0] || !synth_on) begin
            st_q       <= SCPT_ST_HOLD;
            cal_done_q <= 1'b0;
            lock_q     <= 1'b0;
         end else begin
            case (st_q)
               SCPT_ST_HOLD: begin
                  st_q  <= calen_q[0] ? SCPT_ST_CAL : SCPT_ST_LOCKWAIT;
                  tmr_q <= calen_q[0] ? 16'(CAL_CYC - 1) : 16'(LOCK_CYC - 1);
               end
               SCPT_ST_CAL: begin
                  if (tmr_q == 16'h0000) begin
                     cal_done_q <= 1'b1;
                     st_q       <= SCPT_ST_LOCKWAIT;
                     tmr_q      <= 16'(LOCK_CYC - 1);
                  end else begin
                     tmr_q <= tmr_q - 16'h0001;
                  end
               end
               SCPT_ST_LOCKWAIT: begin
                  if (!div_ok) begin
                     st_q <= SCPT_ST_FAIL;
                  end else if (tmr_q == 16'h0000) begin
                     st_q   <= SCPT_ST_LOCKED;
                     lock_q <= 1'b1;
                  end else begin
                     tmr_q <= tmr_q - 16'h0001;
                  end
               end
               SCPT_ST_LOCKED: lock_q <= div_ok;
               default: lock_q <= 1'b0;
            endcase
         end
      end
   end

   // Clock outputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reference_repeat_output <= 1'b0;
         aux_clock_out_c         <= 1'b0;
         aux_clock_out_d         <= 1'b0;
         trigger_clock_output    <= 1'b0;
         sample_clk_select       <= 1'b0;
         synth_reset_out         <= 1'b1;
         noise_suppress          <= 2'h0;
      end else if (ce) begin
         reference_repeat_output <= refo_d;
         aux_clock_out_c         <= auxc_d;
         aux_clock_out_d         <= auxd_d;
         trigger_clock_output    <= trig_d;
         sample_clk_select       <= sclk_sel_d;
         synth_reset_out         <= hold_q[0] | ~synth_on;
         noise_suppress          <= noise_q[`SCPT_NOISE_F];
      end
   end

   scpt_clk_div #(.W(8)) u_ref_d2 (
      .clk(clk), .nrst(nrst), .ce(ce), .tick(ref_rise),
      .div(`SCPT_DIV2), .clk_out(ref_d2));

   scpt_clk_div #(.W(8)) u_ref_d4 (
      .clk(clk), .nrst(nrst), .ce(ce), .tick(ref_rise),
      .div(`SCPT_DIV4), .clk_out(ref_d4));

   scpt_clk_div #(.W(8)) u_ser_div (
      .clk(clk), .nrst(nrst), .ce(ce), .tick(serial_line_tick),
      .div({4'h0, trig_q[`SCPT_TRIG_DIV]}), .clk_out(ser_div));

   scpt_marker_path #(.LAT(MARK_LAT)) u_mark (
      .clk(clk), .nrst(nrst), .ce(ce), .marker_input(marker_input),
      .ts_out_en(mark_q[`SCPT_MARK_OUT]),
      .recv_en(mark_q[`SCPT_MARK_RECV]),
      .sample_in(sample_in), .sample_valid(sample_valid),
      .marker_retimed(mark_rt), .link_word(link_word),
      .link_valid(link_valid));

   pd_outputs_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && pd_s_q |=> !reference_repeat_output && !aux_clock_out_c
                       && !aux_clock_out_d && !trigger_clock_output)
      else $error("clock output active in power down");

   trig_off_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && !trig_en |=> !trigger_clock_output)
      else $error("trigger output active while disabled");

   trig_marker_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && trig_en && trig_mark && !pd_s_q
      |=> trigger_clock_output == $past(mark_rt))
      else $error("trigger does not follow marker");

   refo_gate_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && (!synth_on || !refo_q[0]) |=> !reference_repeat_output)
      else $error("reference repeat active without synth");

   bypass_sel_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && !syn_s_q && !sel_s_q |=> !sample_clk_select)
      else $error("synthesizer not bypassed");

   cal_end_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && st_q == SCPT_ST_CAL && tmr_q == 16'h0000
      && !hold_q[0] && synth_on |=> cal_done_q)
      else $error("calibration done not set at end");

   lock_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      lock_q |-> !$past(hold_q[0]) && div_ok)
      else $error("lock reported while held or bad dividers");

   divn_write_a: assert property (@(posedge clk) disable iff (!nrst)
      ce && wr_stb && addr_q == `SCPT_A_DIVN |=> n_q == $past(wdata))
      else $error("feedback divider write lost");

endmodule : scpt_top

// ==== test/scpt_ref_model.sv ====
`timescale 1ns/10ps

module scpt_ref_model (
   input  wire logic clk,
   input  wire logic mark_lvl,
   output logic      diff_ref_input,
   output logic      single_ended_ref_input,
   output logic      marker_input
);
   logic [3:0] cnt_q = 4'h0;

   // Free-running references, differential four times the faster
   always_ff @(posedge clk) begin
      cnt_q <= cnt_q + 4'h1;
   end
   assign diff_ref_input         = cnt_q[1];
   assign single_ended_ref_input = cnt_q[3];
   // Trigger event source
   assign marker_input           = mark_lvl;
endmodule : scpt_ref_model

// ==== test/scpt_top_tb.sv ====
`timescale 1ns/10ps
`include "scpt_consts.svh"

module scpt_top_tb;
   logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1;
   logic        spi_sclk = 1'b0, spi_csn = 1'b1, spi_sdi = 1'b0;
   logic        spi_sdo, spi_sdo_oe, mark_lvl = 1'b0;
   logic        synth_enable_pin = 1'b1, ref_select_pin = 1'b1;
   logic        power_down_pin = 1'b0, serial_line_tick = 1'b0;
   logic [1:0]  aux_clock_config_pins = 2'h1, noise_suppress;
   logic        diff_ref_input, single_ended_ref_input, marker_input;
   logic [11:0] sample_in = 12'h000, link_word, r;
   logic        sample_valid = 1'b1, link_valid, sample_clk_select;
   logic        synth_reset_out, reference_repeat_output;
   logic        aux_clock_out_c, aux_clock_out_d, trigger_clock_output;
   logic [3:0]  outs, prev;
   logic [7:0]  pv [3] = '{8'h24, 8'h17, 8'h43};
   int          tog [4];
   int          err_count = 0, checks = 0;
   integer      seed = 32'h447B2176;

   scpt_top scpt_top_i (.clk, .nrst, .ce, .spi_sclk, .spi_csn, .spi_sdi,
      .spi_sdo, .spi_sdo_oe, .synth_enable_pin, .ref_select_pin,
      .power_down_pin, .aux_clock_config_pins, .diff_ref_input,
      .single_ended_ref_input, .serial_line_tick, .marker_input,
      .sample_in, .sample_valid, .link_word, .link_valid,
      .sample_clk_select, .synth_reset_out, .noise_suppress,
      .reference_repeat_output, .aux_clock_out_c, .aux_clock_out_d,
      .trigger_clock_output);
   scpt_ref_model scpt_ref_model_i (.clk, .mark_lvl, .diff_ref_input,
      .single_ended_ref_input, .marker_input);

   always #2.5 clk = ~clk;
   assign outs = {trigger_clock_output, aux_clock_out_d, aux_clock_out_c,
                  reference_repeat_output};
   always @(posedge clk) begin
      prev <= outs;
      serial_line_tick <= 1'($random(seed));
      for (int i = 0; i < 4; i++) begin
         if (outs[i] !== prev[i]) tog[i]++;
      end
   end

   function automatic logic [11:0] link_exp(logic [11:0] s, logic m,
                                            logic en);
      return en ? {s[11:1], m} : s;
   endfunction : link_exp
   function automatic logic lock_exp(logic [7:0] d, logic [7:0] n);
      int p;
      p = d[7:4] * d[3:0];
      return (p inside {5, 6, 8, 10, 12, 16}) && (n != 8'h00);
   endfunction : lock_exp

   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic spi(input logic rw, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      logic [23:0] f;
      f = {rw, a, d};
      @(posedge clk) spi_csn <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk) spi_sdi <= f[23-i];
         repeat (6) @(posedge clk);
         if (i >= 16) q[23-i] = spi_sdo;
         if (i >= 16) chk(12'(spi_sdo_oe), 12'(rw));
         spi_sclk <= 1'b1;
         repeat (6) @(posedge clk);
         spi_sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      spi_csn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : spi
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      spi(1'b0, a, d, q);
   endtask : wr
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      spi(1'b1, a, 8'h00, q);
      chk({4'h0, q}, {4'h0, e});
   endtask : rd
   task automatic measure;
      repeat (8) @(posedge clk);
      #1;
      foreach (tog[i]) tog[i] = 0;
      repeat (64) @(posedge clk);
      #1;
   endtask : measure
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end

   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk(12'(trigger_clock_output), 12'h0);
      rd(`SCPT_A_HOLD, 8'h01);
      rd(`SCPT_A_REFO, 8'h01);
      rd(15'h0100, 8'h00);
      wr(`SCPT_A_CALDONE, 8'hFF);
      rd(`SCPT_A_CALDONE, 8'h00);
      wr(`SCPT_A_NOISE, 8'h03);
      chk(12'(noise_suppress), 12'h3);
      $display("test registers done");
      measure;
      chk(12'(sample_clk_select), 12'h1);
      chk(12'(tog[0] inside {[1:16]}), 12'h1);
      chk(12'(tog[1] > 0 && tog[2] > 0), 12'h1);
      @(posedge clk) ref_select_pin <= 1'b0;
      measure;
      chk(12'(tog[0] > 16), 12'h1);
      wr(`SCPT_A_REFO, 8'h00);
      measure;
      chk(12'(tog[0]), 12'h0);
      wr(`SCPT_A_REFO, 8'h01);
      power_down_pin <= 1'b1;
      measure;
      chk(12'(outs), 12'h0);
      chk(12'(tog[0] + tog[1] + tog[2]), 12'h0);
      @(posedge clk);
      power_down_pin <= 1'b0;
      synth_enable_pin <= 1'b0;
      aux_clock_config_pins <= 2'h0;
      measure;
      chk(12'(sample_clk_select), 12'h0);
      chk(12'(synth_reset_out), 12'h1);
      chk(12'(tog[0] + tog[1] + tog[2]), 12'h0);
      @(posedge clk) synth_enable_pin <= 1'b1;
      wr(`SCPT_A_AUX, 8'h1A);
      measure;
      chk(12'(tog[1] > 0 && tog[2] > 0), 12'h1);
      $display("test clock outputs done");
      foreach (pv[k]) begin
         r = 12'($random(seed) & 8'h1F);
         wr(`SCPT_A_HOLD, 8'h01);
         wr(`SCPT_A_DIVPV, pv[k]);
         wr(`SCPT_A_DIVN, r[7:0]);
         rd(`SCPT_A_DIVPV, pv[k]);
         rd(`SCPT_A_DIVN, r[7:0]);
         wr(`SCPT_A_CALEN, 8'h01);
         wr(`SCPT_A_HOLD, 8'h00);
         repeat (700) @(posedge clk);
         rd(`SCPT_A_CALDONE, 8'h01);
         rd(`SCPT_A_LOCK, 8'(lock_exp(pv[k], r[7:0])));
      end
      chk(12'(synth_reset_out), 12'h0);
      $display("test lock sequence done");
      wr(`SCPT_A_TRIG, 8'h21);
      measure;
      chk(12'(tog[3] > 0), 12'h1);
      wr(`SCPT_A_TRIG, 8'h27);
      for (int m = 1; m >= 0; m--) begin
         @(posedge clk) mark_lvl <= m[0];
         repeat (12) @(posedge clk);
         #1;
         chk(12'(trigger_clock_output), 12'(m));
      end
      wr(`SCPT_A_MARK, 8'h03);
      for (int m = 0; m < 3; m++) begin
         if (m == 2) wr(`SCPT_A_MARK, 8'h00);
         @(posedge clk) mark_lvl <= m[0];
         repeat (12) @(posedge clk);
         for (int j = 0; j < 16; j++) begin
            r = $random(seed);
            @(posedge clk) begin
               sample_in    <= r;
               sample_valid <= r[1];
            end
            @(posedge clk);
            #1;
            chk(link_word, link_exp(r, m[0], m != 2));
            chk(12'(link_valid), 12'(r[1]));
         end
      end
      $display("test marker path done");
      tally_and_finish;
   end
endmodule : scpt_top_tb
